// ### logic/csr_params.svh
// Reset-time field values and field layout for the chip-select reset configuration block
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

`define CSR_NUM_SEL 11
`define CSR_BASE_W 13
`define CSR_BASE_RST 13'h0000
// Block size encodings
`define CSR_BLK_2K 3'h0
`define CSR_BLK_1M 3'h7
// Byte field encodings
`define CSR_BYTE_OFF 2'h0
`define CSR_BYTE_BOTH 2'h3
// Read/write field encodings
`define CSR_RW_RSVD 2'h0
`define CSR_RW_BOTH 2'h3
// Acknowledge field: wait states, 4'hD gives 13
`define CSR_ACK_NOWAIT 4'h0
`define CSR_ACK_13WAIT 4'hD
// Space field encodings
`define CSR_SPACE_CPU 2'h0
`define CSR_SPACE_SU 2'h3
`define CSR_LEVEL_ANY 3'h0
`define CSR_MODE_ASYNC 1'h0
`define CSR_STRB_ADDR 1'h0
`define CSR_AVEC_EXT 1'h0
// Processor first vector fetch address
`define CSR_VECTOR_ADDR 24'h000000

`endif

// ### logic/csr_pkg.sv
// Types for the chip-select reset configuration block
package csr_pkg;
    typedef enum logic [1:0] {CSR_IN_RESET, CSR_CAPTURE, CSR_RUN} csr_phase_type;
endpackage

// ### logic/csr_reset_config.sv
// Reset configuration of chip-select pin functions, base and option fields
// What this block does
// - Low bit of each general select pin-function field resets to one.
// - High bit of general fields zero to six comes from data lines one to seven in reset; fields seven to ten reset to zero and are set to one at capture.
// - Sampled data lines have weak pull-ups so undriven gives chip-select function.
// - General select byte fields reset disabled so no general select fires.
// - General selects reset base zero, 2K, async, reserved, addr strobe, no waits, CPU space.
// - Processor fetches first vectors from address zero, supervisor program space.
// - High bit of boot pin-function field resets to one.
// - Boot option byte field resets to both bytes, boot select enabled.
// - Data line zero in reset sets boot width: low 8-bit, high 16-bit.
// - Data line zero weakly pulled high, default 16-bit boot port.
// - Boot base field resets to zero so the first access matches.
// - Boot block size resets to 1 Mbyte.
// - Boot options reset async, read/write, addr strobe, 13 waits, sup/user, any level, external.
`timescale 1ns/100ps
`include "csr_params.svh"

module csr_reset_config
    import csr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_data_pin,
    input wire logic i_sw_wr_pin_fn,
    input wire logic [21:0] i_sw_pin_fn_general,
    input wire logic [1:0] i_sw_pin_fn_boot,
    input wire logic [23:0] i_bus_addr,
    input wire logic i_bus_valid,
    output logic o_data_pullup_en,
    output logic [21:0] o_pin_fn_general,
    output logic [1:0] o_pin_fn_boot,
    output logic o_boot_width16,
    output logic [12:0] o_gen_base,
    output logic [2:0] o_gen_blk,
    output logic o_gen_mode,
    output logic [1:0] o_gen_byte,
    output logic [1:0] o_gen_rw,
    output logic o_gen_strb,
    output logic [3:0] o_gen_ack,
    output logic [1:0] o_gen_space,
    output logic [2:0] o_gen_level,
    output logic o_gen_avec,
    output logic [12:0] o_boot_base,
    output logic [2:0] o_boot_blk,
    output logic o_boot_mode,
    output logic [1:0] o_boot_byte,
    output logic [1:0] o_boot_rw,
    output logic o_boot_strb,
    output logic [3:0] o_boot_ack,
    output logic [1:0] o_boot_space,
    output logic [2:0] o_boot_level,
    output logic o_boot_avec,
    output logic o_boot_select_n,
    output logic o_config_ready
);

    csr_phase_type phase;
    csr_phase_type next_phase;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic [7:0] data_s3;
    logic [21:0] pin_fn_general;
    logic [1:0] pin_fn_boot;
    logic [21:0] next_pin_fn_general;
    logic [1:0] next_pin_fn_boot;
    logic boot_select_n;
    localparam logic [23:0] vector_addr = `CSR_VECTOR_ADDR;

    // Pull-ups enabled on all sampled lines; off once configuration is held
    assign o_data_pullup_en = (phase != CSR_RUN);

    // Pin synchroniser, three stages
    // No reset: the straps must be sampled while reset is held
    always_ff @(posedge i_core_clk)
    begin
        data_s1 <= i_data_pin;
        data_s2 <= data_s1;
        data_s3 <= data_s2;
    end

    // Phase: enter capture on the first edge after release (synchroniser filled during reset), then run
    assign next_phase = (phase == CSR_IN_RESET) ? CSR_CAPTURE : CSR_RUN;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            phase <= CSR_IN_RESET;
        else
            phase <= next_phase;
    end

    // Capture from agreeing stages; fall back to pull-up default otherwise
    genvar g;
    generate
        for (g = 0; g < `CSR_NUM_SEL; g++)
        begin : gen_fn
            logic hi_bit;
            if (g < 7)
            begin : gen_strap
                assign hi_bit = (data_s2[g + 1] == data_s3[g + 1]) ? data_s3[g + 1] : 1'b1;
            end
            else
            begin : gen_fixed
                // No strap line for these fields; pull-up level
                assign hi_bit = 1'b1;
            end
            // Software writes before run are refused
            assign next_pin_fn_general[2 * g + 1] = (phase == CSR_CAPTURE) ? hi_bit :
                (i_sw_wr_pin_fn && phase == CSR_RUN) ?
                i_sw_pin_fn_general[2 * g + 1] : pin_fn_general[2 * g + 1];
            assign next_pin_fn_general[2 * g] = (i_sw_wr_pin_fn && phase == CSR_RUN) ?
                i_sw_pin_fn_general[2 * g] : pin_fn_general[2 * g];
        end
    endgenerate

    assign next_pin_fn_boot[1] = (i_sw_wr_pin_fn && phase == CSR_RUN) ? i_sw_pin_fn_boot[1] : pin_fn_boot[1];
    assign next_pin_fn_boot[0] = (phase == CSR_CAPTURE) ?
        ((data_s2[0] == data_s3[0]) ? data_s3[0] : 1'b1) :
        ((i_sw_wr_pin_fn && phase == CSR_RUN) ? i_sw_pin_fn_boot[0] : pin_fn_boot[0]);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pin_fn_general <= 22'h155555;
            pin_fn_boot <= 2'h3;
        end
        else
        begin
            pin_fn_general <= next_pin_fn_general;
            pin_fn_boot <= next_pin_fn_boot;
        end
    end

    assign o_pin_fn_general = pin_fn_general;
    assign o_pin_fn_boot = pin_fn_boot;
    assign o_boot_width16 = pin_fn_boot[0];
    assign o_config_ready = (phase == CSR_RUN);

    // General select defaults
    assign o_gen_base = `CSR_BASE_RST;
    assign o_gen_blk = `CSR_BLK_2K;
    assign o_gen_mode = `CSR_MODE_ASYNC;
    assign o_gen_byte = `CSR_BYTE_OFF;
    assign o_gen_rw = `CSR_RW_RSVD;
    assign o_gen_strb = `CSR_STRB_ADDR;
    assign o_gen_ack = `CSR_ACK_NOWAIT;
    assign o_gen_space = `CSR_SPACE_CPU;
    assign o_gen_level = `CSR_LEVEL_ANY;
    assign o_gen_avec = `CSR_AVEC_EXT;

    // Boot select defaults
    assign o_boot_base = `CSR_BASE_RST;
    assign o_boot_blk = `CSR_BLK_1M;
    assign o_boot_mode = `CSR_MODE_ASYNC;
    assign o_boot_byte = `CSR_BYTE_BOTH;
    assign o_boot_rw = `CSR_RW_BOTH;
    assign o_boot_strb = `CSR_STRB_ADDR;
    assign o_boot_ack = `CSR_ACK_13WAIT;
    assign o_boot_space = `CSR_SPACE_SU;
    assign o_boot_level = `CSR_LEVEL_ANY;
    assign o_boot_avec = `CSR_AVEC_EXT;

    // Boot select fires on any access in the first 1 Mbyte while boot pin-function high bit is set (vector fetch at zero)
    logic boot_hit;
    assign boot_hit = i_bus_valid && pin_fn_boot[1] &&
        (i_bus_addr[23:20] == vector_addr[23:20]);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            boot_select_n <= 1'b1;
        else
            boot_select_n <= ~boot_hit;
    end

    assign o_boot_select_n = boot_select_n;

    // Capture cycle, then run
    sequence capture_then_run_s;
        (phase == CSR_CAPTURE) ##1 (phase == CSR_RUN);
    endsequence

    boot_fires_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_bus_valid && i_bus_addr == vector_addr && pin_fn_boot[1]) |=> !o_boot_select_n)
        else $error("Boot select missed vector fetch");
    boot_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_bus_valid |=> o_boot_select_n)
        else $error("Boot select without access");
    gen_low_bits_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase != CSR_RUN) |-> (pin_fn_general[0] && pin_fn_general[20]))
        else $error("General low bit not one");
    capture_d1_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_CAPTURE && data_s2[1] == data_s3[1]) |=> (pin_fn_general[1] == $past(data_s3[1])))
        else $error("Data line one not captured");
    capture_d7_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_CAPTURE && data_s2[7] == data_s3[7]) |=> (pin_fn_general[13] == $past(data_s3[7])))
        else $error("Data line seven not captured");
    fixed_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_CAPTURE) |=> (pin_fn_general[21] && pin_fn_general[19] && pin_fn_general[17] &&
        pin_fn_general[15]))
        else $error("Unstrapped field not chip select");
    width_cap_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_CAPTURE && data_s2[0] == data_s3[0]) |=> (o_boot_width16 == $past(data_s3[0])))
        else $error("Boot width not captured");
    width_default_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_IN_RESET) |-> o_boot_width16)
        else $error("Boot width not 16-bit in reset");
    hold_cfg_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_RUN && !i_sw_wr_pin_fn) |=> $stable(pin_fn_general) && $stable(pin_fn_boot))
        else $error("Configuration changed without write");
    early_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_IN_RESET) |=> $stable(pin_fn_general) && $stable(pin_fn_boot))
        else $error("Configuration changed before capture");
    sw_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_RUN && i_sw_wr_pin_fn) |=>
        (pin_fn_general == $past(i_sw_pin_fn_general) && pin_fn_boot == $past(i_sw_pin_fn_boot)))
        else $error("Software write not applied");
    boot_msb_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase != CSR_RUN) |-> pin_fn_boot[1])
        else $error("Boot pin function not chip select");
    phase_seq_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_IN_RESET) |=> capture_then_run_s)
        else $error("Phase sequence wrong");
    pullup_held_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (phase == CSR_CAPTURE) |-> (o_data_pullup_en && $past(o_data_pullup_en)))
        else $error("Pull-up off during sampling");

endmodule

// ### bench/csr_strap_model.sv
// Strap driver and data bus model on the far side of the reset configuration block
`timescale 1ns/100ps
module csr_strap_model (
    input wire logic i_core_clk,
    input wire logic i_drive_en,
    input wire logic [7:0] i_strap_val,
    input wire logic i_pullup_en,
    output logic [7:0] o_data_pin
);
    logic [7:0] float_pat = 8'h5A;
    // Released bus with pull-ups off shows a changing pattern, never the last value
    always @(posedge i_core_clk)
    begin
        float_pat <= ~float_pat;
    end
    assign o_data_pin = i_drive_en ? i_strap_val : (i_pullup_en ? 8'hFF : float_pat);
endmodule

// ### bench/testbench.sv
// Self-checking bench for the chip-select reset configuration block
`timescale 1ns/100ps
`include "csr_params.svh"
module testbench;
    logic i_core_clk = 0, i_rst = 1, drv = 1, i_sw_wr_pin_fn = 0, i_bus_valid = 0;
    logic [7:0] strap = 8'hFF;
    logic [7:0] data_pin;
    logic [21:0] i_sw_pin_fn_general = 22'h000000, o_pin_fn_general;
    logic [1:0] i_sw_pin_fn_boot = 2'h3, o_pin_fn_boot, o_gen_byte, o_gen_rw, o_gen_space;
    logic [1:0] o_boot_byte, o_boot_rw, o_boot_space;
    logic [23:0] i_bus_addr = 24'h000000;
    logic o_data_pullup_en, o_boot_width16, o_gen_mode, o_gen_strb, o_gen_avec;
    logic o_boot_mode, o_boot_strb, o_boot_avec;
    logic o_boot_select_n, o_config_ready;
    logic [12:0] o_gen_base, o_boot_base;
    logic [2:0] o_gen_blk, o_gen_level, o_boot_blk, o_boot_level;
    logic [3:0] o_gen_ack, o_boot_ack;
    logic [31:0] gen_fields, boot_fields;
    int num_errors = 0, n_checks = 0;
    // Rows: strap inputs beside the fields they should give
    logic [7:0] row_strap [5] = '{8'hFF, 8'h00, 8'hA5, 8'h5A, 8'h00};
    logic row_drv [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [21:0] row_gen [5] = '{22'h3FFFFF, 22'h3FD555, 22'h3FF75D, 22'h3FDDF7, 22'h3FFFFF};
    logic row_w16 [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [31:0] gen_def = {`CSR_BASE_RST, `CSR_BLK_2K, `CSR_MODE_ASYNC, `CSR_BYTE_OFF, `CSR_RW_RSVD,
        `CSR_STRB_ADDR, `CSR_ACK_NOWAIT, `CSR_SPACE_CPU, `CSR_LEVEL_ANY, `CSR_AVEC_EXT};
    localparam logic [31:0] boot_def = {`CSR_BASE_RST, `CSR_BLK_1M, `CSR_MODE_ASYNC, `CSR_BYTE_BOTH, `CSR_RW_BOTH,
        `CSR_STRB_ADDR, `CSR_ACK_13WAIT, `CSR_SPACE_SU, `CSR_LEVEL_ANY, `CSR_AVEC_EXT};
    assign gen_fields = {o_gen_base, o_gen_blk, o_gen_mode, o_gen_byte, o_gen_rw, o_gen_strb, o_gen_ack, o_gen_space,
        o_gen_level, o_gen_avec};
    assign boot_fields = {o_boot_base, o_boot_blk, o_boot_mode, o_boot_byte, o_boot_rw, o_boot_strb, o_boot_ack,
        o_boot_space, o_boot_level, o_boot_avec};
    initial forever #5 i_core_clk = ~i_core_clk;
    csr_strap_model part_u (.i_core_clk(i_core_clk), .i_drive_en(drv), .i_strap_val(strap),
        .i_pullup_en(o_data_pullup_en), .o_data_pin(data_pin));
    csr_reset_config dut_u (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_data_pin(data_pin), .i_sw_wr_pin_fn(i_sw_wr_pin_fn),
        .i_sw_pin_fn_general(i_sw_pin_fn_general), .i_sw_pin_fn_boot(i_sw_pin_fn_boot), .i_bus_addr(i_bus_addr),
        .i_bus_valid(i_bus_valid), .o_data_pullup_en(o_data_pullup_en), .o_pin_fn_general(o_pin_fn_general),
        .o_pin_fn_boot(o_pin_fn_boot), .o_boot_width16(o_boot_width16), .o_gen_base(o_gen_base),
        .o_gen_blk(o_gen_blk), .o_gen_mode(o_gen_mode), .o_gen_byte(o_gen_byte), .o_gen_rw(o_gen_rw),
        .o_gen_strb(o_gen_strb), .o_gen_ack(o_gen_ack), .o_gen_space(o_gen_space), .o_gen_level(o_gen_level),
        .o_gen_avec(o_gen_avec), .o_boot_base(o_boot_base), .o_boot_blk(o_boot_blk), .o_boot_mode(o_boot_mode),
        .o_boot_byte(o_boot_byte), .o_boot_rw(o_boot_rw), .o_boot_strb(o_boot_strb), .o_boot_ack(o_boot_ack),
        .o_boot_space(o_boot_space), .o_boot_level(o_boot_level), .o_boot_avec(o_boot_avec),
        .o_boot_select_n(o_boot_select_n), .o_config_ready(o_config_ready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cfg_reset(input logic d, input logic [7:0] s);
        i_rst = 1;
        drv = d;
        strap = s;
        repeat (6) @(negedge i_core_clk);
        chk(o_pin_fn_general, 22'h155555);
        chk({o_pin_fn_boot[1], o_data_pullup_en, o_boot_select_n}, 3'h7);
        i_rst = 0;
        for (int k = 0; k < 10 && o_config_ready !== 1'b1; k++)
            @(negedge i_core_clk);
        drv = 0;
        chk(o_config_ready, 1'b1);
    endtask
    task automatic access(input logic [23:0] a, input logic exp_n);
        i_bus_valid = 1;
        i_bus_addr = a;
        @(negedge i_core_clk);
        i_bus_valid = 0;
        chk(o_boot_select_n, exp_n);
        @(negedge i_core_clk);
        chk(o_boot_select_n, 1'b1);
    endtask
    initial
    begin
        // About six times the expected run
        #5000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        @(negedge i_core_clk);
        for (int r = 0; r < 5; r++)
        begin
            cfg_reset(row_drv[r], row_strap[r]);
            repeat (4) @(negedge i_core_clk);
            chk(o_pin_fn_general, row_gen[r]);
            chk({o_pin_fn_boot, o_boot_width16}, {1'b1, row_w16[r], row_w16[r]});
            chk(gen_fields, gen_def);
            chk(boot_fields, boot_def);
            $display("row %0d done", r);
        end
        access(`CSR_VECTOR_ADDR, 1'b0);
        access(24'h0FFFFE, 1'b0);
        access(24'h100000, 1'b1);
        $display("boot access test done");
        i_sw_pin_fn_general = 22'h2AAAAA;
        i_sw_pin_fn_boot = 2'h0;
        i_sw_wr_pin_fn = 1;
        @(negedge i_core_clk);
        i_sw_wr_pin_fn = 0;
        chk({o_pin_fn_general, o_pin_fn_boot, o_boot_width16}, {22'h2AAAAA, 3'h0});
        access(`CSR_VECTOR_ADDR, 1'b1);
        $display("software write test done");
        // Strap changes one edge before release; early write must be refused
        i_rst = 1;
        drv = 1;
        strap = 8'h00;
        repeat (5) @(negedge i_core_clk);
        strap = 8'hFF;
        @(negedge i_core_clk);
        i_rst = 0;
        i_sw_wr_pin_fn = 1;
        @(negedge i_core_clk);
        i_sw_wr_pin_fn = 0;
        repeat (2) @(negedge i_core_clk);
        drv = 0;
        chk(o_pin_fn_general, 22'h3FFFFF);
        chk({o_pin_fn_boot, o_boot_width16}, 3'h7);
        $display("strap change and early write test done");
        tally_and_finish();
    end
endmodule
